// ### dv/ldc_host_pwm.sv
// host pwm source feeding the pwm input
`timescale 1ns/1ns
module ldc_host_pwm (
  input  wire logic        sys_clk,
  input  wire logic [15:0] hi_len,
  output logic             pwm_out
);
  // 20 kHz frame sits inside both input ranges; bench keeps hi_len >= 20 clocks
  localparam logic [15:0] PER = 16'h1388;
  logic [15:0] cnt_q = 16'h0000;
  initial pwm_out = 1'b0;
  always @(posedge sys_clk) begin
    cnt_q   <= (cnt_q >= PER - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    pwm_out <= cnt_q < hi_len;
  end
endmodule : ldc_host_pwm

// ### dv/ldc_top_assertions.sv
// port assertions for the led dimming control block
`timescale 1ns/1ns
module ldc_top_chk (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_we,
  input wire logic        reg_re,
  input wire logic [15:0] reg_rdata,
  input wire logic        pwm_in,
  input wire logic        host_bus_en,
  input wire logic        strap_pin_high,
  input wire logic        strap_pin_low,
  input wire logic [7:0]  sink_on,
  input wire logic [14:0] sink_level,
  input wire logic        sink_pulsing
);
  logic       seen_q, bus_q, hi_q, lo_q;
  logic [7:0] age_q;
  logic       pass_m, float_m, hyb_m;
  // straps taken once at the first edge out of reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      seen_q <= 1'b0;
      bus_q  <= 1'b0;
      hi_q   <= 1'b0;
      lo_q   <= 1'b0;
      age_q  <= 8'h00;
    end else begin
      seen_q <= 1'b1;
      if (!seen_q) begin
        bus_q <= host_bus_en;
        hi_q  <= strap_pin_high;
        lo_q  <= strap_pin_low;
      end
      if (age_q != 8'hff) begin
        age_q <= age_q + 8'h01;
      end
    end
  end
  // settle time before pass-through is judged
  assign pass_m  = seen_q && !bus_q && hi_q && (age_q == 8'hff);
  assign float_m = seen_q && !bus_q && !hi_q && !lo_q;
  assign hyb_m   = seen_q && !bus_q && !hi_q && lo_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  pass_follow_a: assert property (pass_m |-> sink_on == {8{$past(pwm_in)}})
    else $error("sinks do not follow pwm input");
  pass_level_a: assert property (pass_m |-> sink_level == ldc_pkg::FULL_SCALE)
    else $error("pass-through level not full scale");
  pass_no_pulse_a: assert property (pass_m |-> !sink_pulsing)
    else $error("pulse mode in pass-through");
  analog_dc_a: assert property (float_m |-> !sink_pulsing)
    else $error("analog strap pulses");
  analog_steady_a: assert property (float_m |-> !$fell(sink_on[0]))
    else $error("analog sink switched off");
  hybrid_level_a: assert property (hyb_m && sink_pulsing |-> sink_level == 15'h1fff)
    else $error("hybrid pulse amplitude wrong");
  hybrid_dc_a: assert property (hyb_m |-> sink_on == 8'h00 || sink_pulsing || sink_level >= 15'h1fff)
    else $error("dc below hybrid switch point");
  min_on_a: assert property ($rose(sink_on[0]) && sink_pulsing |-> sink_on[0] [*8])
    else $error("on pulse too short");
endmodule : ldc_top_chk

bind ldc_top ldc_top_chk ldc_top_chk_inst (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pwm_in(pwm_in),
  .host_bus_en(host_bus_en), .strap_pin_high(strap_pin_high), .strap_pin_low(strap_pin_low),
  .sink_on(sink_on), .sink_level(sink_level), .sink_pulsing(sink_pulsing));

// ### dv/ldc_top_bench.sv
// self-checking bench for the led dimming control block
`timescale 1ns/1ns
module ldc_top_bench;
  localparam logic [7:0] CT = ldc_pkg::ADDR_CTRL;
  localparam logic [7:0] LO = ldc_pkg::ADDR_BRT_LOW;
  localparam logic [7:0] HI = ldc_pkg::ADDR_BRT_HIGH;
  logic        sys_clk, resetn, reg_we, reg_re, pwm_in, host_bus_en, strap_pin_high, strap_pin_low, sink_pulsing;
  logic [7:0]  reg_addr, sink_on;
  logic [15:0] reg_wdata, reg_rdata, hi_len, v;
  logic [14:0] sink_level, thr;
  int          n_fail, checks_done;

  ldc_top ldc_top_inst (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pwm_in(pwm_in), .host_bus_en(host_bus_en),
    .strap_pin_high(strap_pin_high), .strap_pin_low(strap_pin_low), .sink_on(sink_on),
    .sink_level(sink_level), .sink_pulsing(sink_pulsing));
  ldc_host_pwm ldc_host_pwm_inst (.sys_clk(sys_clk), .hi_len(hi_len), .pwm_out(pwm_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge sys_clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1;
    v = reg_rdata;
    chk(what, v, exp);
  endtask : rdc

  task automatic boot(input logic bus, input logic hi, input logic lo, input logic [15:0] h);
    @(posedge sys_clk);
    resetn         <= 1'b0;
    host_bus_en    <= bus;
    strap_pin_high <= hi;
    strap_pin_low  <= lo;
    hi_len         <= h;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
  endtask : boot

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_n

  // sinks copy the input level seen at the previous edge
  task automatic pass_chk(input logic [7:0] m);
    logic p;
    for (int i = 0; i < 6; i++) begin
      wait_n(350);
      @(negedge sys_clk);
      p = pwm_in;
      @(posedge sys_clk);
      #1;
      chk("pass sinks", {8'h00, sink_on}, {8'h00, {8{p}} & m});
    end
  endtask : pass_chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    $display("run exceeded its cycle limit");
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    host_bus_en = 1'b1;
    strap_pin_high = 1'b0;
    strap_pin_low = 1'b0;
    hi_len = 16'h09c4;
    n_fail = 0;
    checks_done = 0;
    boot(1'b1, 1'b0, 1'b0, 16'h09c4);
    rdc(CT, 16'h0000, "ctrl reset");
    rdc(ldc_pkg::ADDR_STR_EN, 16'h00ff, "enable reset");
    wr(8'hfc, 16'hffff);
    rdc(8'hfc, 16'h0000, "unmapped");
    wr(CT, 16'hffff);
    rdc(CT, 16'h03ff, "ctrl fields");
    wr(LO, 16'h00a7);
    rdc(LO, 16'h00a7, "staged low");
    rdc(HI, 16'h0000, "high uncommitted");
    wr(HI, 16'h005c);
    rdc(HI, 16'h005c, "high committed");
    wr(ldc_pkg::ADDR_STR_EN, 16'h000f);
    wr(LO, 16'h0000);
    wr(HI, 16'h0030);
    // code 0x300 is dc only above the lowest switch point
    for (int t = 0; t < 4; t++) begin
      wr(CT, 16'h0221 | 16'(t << 3));
      wait_n(t == 0 ? 40200 : 2700);
      thr = 15'h7fff >> (3 - t);
      chk("pulsing", {15'h0, sink_pulsing}, {15'h0, 15'h1800 < thr});
      chk("level", {1'b0, sink_level}, {1'b0, (15'h1800 < thr) ? thr : 15'h1800});
    end
    rdc(ldc_pkg::ADDR_STATUS, 16'h04fb, "status");
    chk("active strings", {12'h000, v[11:8]}, 16'h0004);
    wr(CT, 16'h0224);
    wr(LO, 16'h0005);
    wr(HI, 16'h0010);
    wait_n(2700);
    chk("analog pulsing", {15'h0, sink_pulsing}, 16'h0000);
    chk("dither level", {1'b0, sink_level}, 16'h0805);
    chk("analog sinks", {8'h00, sink_on}, 16'h000f);
    wr(CT, 16'h0200);
    wait_n(2700);
    chk("duty level", {15'h0, sink_level > 15'h3f00 && sink_level < 15'h4100}, 16'h0001);
    wr(CT, 16'h0260);
    wait_n(10);
    pass_chk(8'h0f);
    chk("pass pulsing", {15'h0, sink_pulsing}, 16'h0000);
    $display("test bus mode done");
    boot(1'b0, 1'b0, 1'b0, 16'h0fa0);
    wr(CT, 16'h0261);
    wait_n(300);
    chk("float pulsing", {15'h0, sink_pulsing}, 16'h0000);
    $display("test analog strap done");
    boot(1'b0, 1'b0, 1'b1, 16'h00fa);
    wait_n(40300);
    chk("hybrid pulsing", {15'h0, sink_pulsing}, 16'h0001);
    chk("hybrid level", {1'b0, sink_level}, 16'h1fff);
    $display("test hybrid strap done");
    boot(1'b0, 1'b1, 1'b0, 16'h03e8);
    wait_n(300);
    strap_pin_high <= 1'b0;
    strap_pin_low  <= 1'b1;
    pass_chk(8'hff);
    $display("test pass strap done");
    tally_and_finish();
  end
endmodule : ldc_top_bench

// ### src/ldc_duty_meter.sv
// measures the duty cycle of the pwm input as a 12-bit code
`timescale 1ns/1ns
module ldc_duty_meter (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        tick,
  input  wire logic        pwm_in,
  output logic [11:0]      duty,
  output logic             duty_valid
);
  typedef enum logic [1:0] {
    DM_IDLE = 2'b00,
    DM_DIV  = 2'b01,
    DM_DONE = 2'b11
  } ldc_dm_state_t;

  ldc_dm_state_t state_q;
  logic          prev_q;
  logic [15:0]   hi_cnt_q;
  logic [15:0]   per_cnt_q;
  logic [15:0]   den_q;
  logic [16:0]   rem_q;
  logic [16:0]   rem2;
  logic [11:0]   quo_q;
  logic [3:0]    step_q;
  logic          rise;
  logic          stalled;

  assign rise    = tick & pwm_in & ~prev_q;
  assign stalled = tick & ~rise & (per_cnt_q == 16'hffff);
  assign rem2    = {rem_q[15:0], 1'b0};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q <= 1'b0;
    end else if (tick) begin
      prev_q <= pwm_in;
    end
  end

  // sampled at the master tick, so resolution drops as input rate rises
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_q  <= 16'h0000;
      per_cnt_q <= 16'h0000;
    end else if (rise) begin
      hi_cnt_q  <= 16'h0001;
      per_cnt_q <= 16'h0001;
    end else if (tick) begin
      if (per_cnt_q != 16'hffff) begin
        per_cnt_q <= per_cnt_q + 16'h0001;
      end
      if (pwm_in && hi_cnt_q != 16'hffff) begin
        hi_cnt_q <= hi_cnt_q + 16'h0001;
      end
    end
  end

  // fraction high/period, one bit per clock; edges during it are ignored
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= DM_IDLE;
      rem_q   <= 17'h00000;
      den_q   <= 16'h0000;
      quo_q   <= 12'h000;
      step_q  <= 4'h0;
    end else begin
      unique case (state_q)
        DM_IDLE: begin
          // skip only an edge at the first tick after reset: nothing counted yet; a later first edge is measured from reset
          if (rise && per_cnt_q != 16'h0000) begin
            if (hi_cnt_q >= per_cnt_q) begin
              quo_q   <= 12'hfff;
              state_q <= DM_DONE;
            end else begin
              rem_q   <= {1'b0, hi_cnt_q};
              den_q   <= per_cnt_q;
              quo_q   <= 12'h000;
              step_q  <= 4'h0;
              state_q <= DM_DIV;
            end
          end
        end
        DM_DIV: begin
          if (rem2 >= {1'b0, den_q}) begin
            rem_q <= rem2 - {1'b0, den_q};
            quo_q <= {quo_q[10:0], 1'b1};
          end else begin
            rem_q <= rem2;
            quo_q <= {quo_q[10:0], 1'b0};
          end
          step_q <= step_q + 4'h1;
          if (step_q == 4'hb) begin
            state_q <= DM_DONE;
          end
        end
        DM_DONE: begin
          state_q <= DM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      duty       <= 12'h000;
      duty_valid <= 1'b0;
    end else begin
      duty_valid <= (state_q == DM_DONE);
      if (state_q == DM_DONE) begin
        duty <= quo_q;
      end else if (stalled) begin
        duty <= pwm_in ? 12'hfff : 12'h000;
      end
    end
  end
endmodule : ldc_duty_meter

// ### src/ldc_pkg.sv
// shared constants, types and helpers for the led dimming control block
package ldc_pkg;
  // master tick: 10.24 MHz out of 100 MHz by a fractional accumulator
  localparam int          CLK_KHZ        = 100_000;
  localparam int          MCLK_KHZ       = 10_240;
  localparam logic [11:0] MCLK_NUM       = 12'h100;
  localparam logic [11:0] MCLK_DEN       = 12'h9c4;
  localparam int          MIN_PULSE_NS   = 200;
  localparam int          MIN_PULSE_TICKS = (MIN_PULSE_NS * MCLK_KHZ + 999_999) / 1_000_000;
  localparam logic [12:0] MIN_PULSE      = 13'(MIN_PULSE_TICKS);

  // register port
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 16;
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_BRT_LOW   = 8'h04;
  localparam logic [7:0]  ADDR_BRT_HIGH  = 8'h08;
  localparam logic [7:0]  ADDR_STR_EN    = 8'h0c;
  localparam logic [7:0]  ADDR_DUTY      = 8'h10;
  localparam logic [7:0]  ADDR_STATUS    = 8'h14;

  // setup_word_two field positions
  localparam int          CTRL_DIM_MODE  = 0;
  localparam int          CTRL_LOG       = 1;
  localparam int          CTRL_DITHER    = 2;
  localparam int          CTRL_TP_LSB    = 3;
  localparam int          CTRL_SRC_LSB   = 5;
  localparam int          CTRL_RATE_LSB  = 7;
  localparam logic [9:0]  CTRL_RST       = 10'h000;
  localparam logic [7:0]  STR_EN_RST     = 8'hff;
  // brightness_code_low: code bits in [7:4], dither fraction in [2:0]
  localparam int          LOW_CODE_LSB   = 4;

  localparam logic [14:0] FULL_SCALE     = 15'h7fff;
  localparam logic [12:0] BASE_PERIOD    = 13'h1000;

  typedef enum logic [1:0] {
    SRC_DUTY    = 2'b00,
    SRC_REG     = 2'b01,
    SRC_PRODUCT = 2'b10,
    SRC_PASS    = 2'b11
  } ldc_src_t;

  localparam logic [1:0]  TP_12P5        = 2'b00;
  localparam logic [1:0]  TP_25          = 2'b01;
  localparam logic [1:0]  TP_50          = 2'b10;
  localparam logic [1:0]  TP_100         = 2'b11;
  localparam logic [2:0]  RATE_2K5       = 3'h0;
  localparam logic [2:0]  RATE_40K       = 3'h4;

  function automatic logic [3:0] ones8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + 4'(v[i]);
    end
    return n;
  endfunction : ones8

  // codes above the five documented settings fall back to the slowest rate
  function automatic logic [12:0] rate_period(input logic [2:0] sel);
    if (sel > RATE_40K) begin
      return BASE_PERIOD;
    end
    return BASE_PERIOD >> sel;
  endfunction : rate_period
endpackage : ldc_pkg

// ### src/ldc_string_pwm.sv
// phase-shifted pulse generator for the eight string sinks
`timescale 1ns/1ns
module ldc_string_pwm (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        tick,
  input  wire logic [2:0]  rate_sel,
  input  wire logic [12:0] on_cnt,
  input  wire logic [14:0] amp_in,
  input  wire logic [7:0]  str_en,
  output logic [7:0]       str_on,
  output logic [14:0]      amp,
  output logic             cycle_start,
  output logic [3:0]       active_cnt
);
  logic [12:0] cnt_q;
  logic [12:0] period_q;
  logic [12:0] on_q;
  logic [7:0]  en_q;
  logic [12:0] off_q [8];
  logic [12:0] period_nx;
  logic        wrap;

  // rank of a string among the enabled ones, spread over one period
  function automatic logic [12:0] phase_off(input logic [3:0] rank, input logic [3:0] nact,
                                            input logic [12:0] per);
    logic [16:0] p;
    p = 17'(rank) * 17'(per);
    if (nact == 4'h0) begin
      return 13'h0000;
    end
    return 13'(p / 17'(nact));
  endfunction : phase_off

  assign period_nx = ldc_pkg::rate_period(rate_sel);
  assign wrap      = (cnt_q == period_q - 13'h0001);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q       <= 13'h0000;
      cycle_start <= 1'b0;
    end else begin
      cycle_start <= tick & wrap;
      if (tick) begin
        cnt_q <= wrap ? 13'h0000 : cnt_q + 13'h0001;
      end
    end
  end

  // new settings and phases only at a cycle boundary, never mid-cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      period_q   <= ldc_pkg::BASE_PERIOD;
      on_q       <= 13'h0000;
      amp        <= 15'h0000;
      en_q       <= 8'h00;
      active_cnt <= 4'h0;
      for (int i = 0; i < 8; i++) begin
        off_q[i] <= 13'h0000;
      end
    end else if (tick && wrap) begin
      period_q   <= period_nx;
      on_q       <= on_cnt;
      amp        <= amp_in;
      en_q       <= str_en;
      active_cnt <= ldc_pkg::ones8(str_en);
      for (int i = 0; i < 8; i++) begin
        off_q[i] <= phase_off(ldc_pkg::ones8(str_en & ((8'h01 << i) - 8'h01)),
                              ldc_pkg::ones8(str_en), period_nx);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      str_on <= 8'h00;
    end else if (tick) begin
      for (int i = 0; i < 8; i++) begin
        if (cnt_q >= off_q[i]) begin
          str_on[i] <= en_q[i] & ((cnt_q - off_q[i]) < on_q);
        end else begin
          str_on[i] <= en_q[i] & ((cnt_q + period_q - off_q[i]) < on_q);
        end
      end
    end
  end
endmodule : ldc_string_pwm

// ### src/ldc_top.sv
// led dimming control: source select, mapping, hybrid dimming and sink drive
// Function
// - select bit 0 gives pure DC dimming
// - select bit 1 pulses strings below threshold
// - phases spaced 360 degrees over active strings
// - rate field picks 2.5 to 40 kHz
// - hybrid: DC above switch point, pulses below
// - code 11: DC only at full brightness
// - code 10: DC from 50%, else 50% pulses
// - code 01: DC from 25%, else 25% pulses
// - code 00: DC from 12.5%, else 12.5% pulses
// - pulse width inverse to amplitude, 200ns minimum
// - strap latched once at startup without bus
// - strap low hybrid 25%, float analog, high pass-through
// - strapped low without bus runs 2.5 kHz
// - code 11 passes pwm input straight through
// - code 00 uses measured input duty only
// - code 01 uses register brightness code only
// - code 10 multiplies mapped code by duty
// - linear mapping, 4095 or 32767 states
// - log mapping, 1023 or 8191 states
// - without bus, dimming follows input duty only
// - new brightness only at cycle start
// - measurement and pulses run on 10.24 MHz
// - dither appends three fraction bits
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module ldc_top (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic [15:0]      reg_rdata,
  input  wire logic        pwm_in,
  input  wire logic        host_bus_en,
  input  wire logic        strap_pin_high,
  input  wire logic        strap_pin_low,
  output logic [7:0]       sink_on,
  output logic [14:0]      sink_level,
  output logic             sink_pulsing
);
  typedef enum logic {
    ST_SAMPLE = 1'b0,
    ST_HOLD   = 1'b1
  } ldc_strap_state_t;

  ldc_strap_state_t strap_state_q;
  logic             bus_mode_q;
  logic [1:0]       strap_code_q;

  logic [11:0]      acc_q;
  logic             tick_q;

  logic [9:0]       ctrl_q;
  logic [7:0]       low_stage_q;
  logic [11:0]      code_q;
  logic [2:0]       dither_q;
  logic [7:0]       str_en_q;

  logic             eff_dim_mode;
  logic             eff_log;
  logic             eff_dither;
  logic [1:0]       eff_tp;
  ldc_pkg::ldc_src_t eff_src;
  logic [2:0]       eff_rate;

  logic [11:0]      duty;
  logic             duty_valid;
  logic [14:0]      map_reg;
  logic [14:0]      map_duty;
  logic [26:0]      prod;
  logic [14:0]      level_d;
  logic [14:0]      level_q;

  logic [1:0]       shift;
  logic [14:0]      thr;
  logic             dc_out;
  logic [17:0]      scaled;
  logic [31:0]      on_prod;
  logic [12:0]      period;
  logic [12:0]      on_raw;
  logic [12:0]      on_cnt;
  logic [14:0]      amp_d;

  logic [7:0]       gen_on;
  logic [14:0]      gen_amp;
  logic             gen_cycle;
  logic [3:0]       active_cnt;
  logic             pulsing_q;
  logic             pend_q;

  // shared between register and measured codes
  function automatic logic [14:0] map_level(input logic [11:0] code, input logic [2:0] frac,
                                            input logic log_en, input logic dith_en);
    logic [14:0] lin;
    logic [12:0] x;
    logic [24:0] m;
    lin = dith_en ? {code, frac} : {code, 3'h0};
    // log keeps the top 10 or 13 bits, an exponent and a mantissa
    x = dith_en ? lin[14:2] : {lin[14:5], 3'h0};
    m = 25'({1'b1, x[8:0]}) << x[12:9];
    if (!log_en) begin
      return lin;
    end
    if (x == 13'h0000) begin
      return 15'h0000;
    end
    return m[24:10];
  endfunction : map_level

  // master tick, the common time base for measuring and pulsing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      acc_q  <= 12'h000;
      tick_q <= 1'b0;
    end else if (acc_q + ldc_pkg::MCLK_NUM >= ldc_pkg::MCLK_DEN) begin
      acc_q  <= acc_q + ldc_pkg::MCLK_NUM - ldc_pkg::MCLK_DEN;
      tick_q <= 1'b1;
    end else begin
      acc_q  <= acc_q + ldc_pkg::MCLK_NUM;
      tick_q <= 1'b0;
    end
  end

  // straps are caught on the first edge after release and then frozen
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strap_state_q <= ST_SAMPLE;
      bus_mode_q    <= 1'b0;
      strap_code_q  <= 2'b00;
    end else begin
      unique case (strap_state_q)
        ST_SAMPLE: begin
          bus_mode_q    <= host_bus_en;
          strap_code_q  <= {strap_pin_high, strap_pin_low};
          strap_state_q <= ST_HOLD;
        end
        ST_HOLD: begin
          strap_state_q <= ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q   <= ldc_pkg::CTRL_RST;
      str_en_q <= ldc_pkg::STR_EN_RST;
    end else if (reg_we) begin
      if (reg_addr == ldc_pkg::ADDR_CTRL) begin
        ctrl_q <= reg_wdata[9:0];
      end
      if (reg_addr == ldc_pkg::ADDR_STR_EN) begin
        str_en_q <= reg_wdata[7:0];
      end
    end
  end

  // the low write is staged; the high write commits the whole code
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      low_stage_q <= 8'h00;
      code_q      <= 12'h000;
      dither_q    <= 3'h0;
    end else if (reg_we && reg_addr == ldc_pkg::ADDR_BRT_LOW) begin
      low_stage_q <= reg_wdata[7:0];
    end else if (reg_we && reg_addr == ldc_pkg::ADDR_BRT_HIGH) begin
      code_q   <= {reg_wdata[7:0], low_stage_q[ldc_pkg::LOW_CODE_LSB +: 4]};
      dither_q <= low_stage_q[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_re) begin
      unique case (reg_addr)
        ldc_pkg::ADDR_CTRL:     reg_rdata <= {6'h00, ctrl_q};
        ldc_pkg::ADDR_BRT_LOW:  reg_rdata <= {8'h00, low_stage_q};
        ldc_pkg::ADDR_BRT_HIGH: reg_rdata <= {8'h00, code_q[11:4]};
        ldc_pkg::ADDR_STR_EN:   reg_rdata <= {8'h00, str_en_q};
        ldc_pkg::ADDR_DUTY:     reg_rdata <= {4'h0, duty};
        ldc_pkg::ADDR_STATUS:   reg_rdata <= {4'h0, active_cnt, bus_mode_q, pulsing_q,
                                              eff_dim_mode, eff_tp, eff_src, strap_state_q};
        default:                reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // settings in force: registers with the bus, straps without it
  always_comb begin
    eff_dim_mode = ctrl_q[ldc_pkg::CTRL_DIM_MODE];
    eff_log      = ctrl_q[ldc_pkg::CTRL_LOG];
    eff_dither   = ctrl_q[ldc_pkg::CTRL_DITHER];
    eff_tp       = ctrl_q[ldc_pkg::CTRL_TP_LSB +: 2];
    eff_src      = ldc_pkg::ldc_src_t'(ctrl_q[ldc_pkg::CTRL_SRC_LSB +: 2]);
    eff_rate     = ctrl_q[ldc_pkg::CTRL_RATE_LSB +: 3];
    if (!bus_mode_q) begin
      eff_log    = 1'b0;
      eff_dither = 1'b0;
      eff_src    = ldc_pkg::SRC_DUTY;
      eff_rate   = ldc_pkg::RATE_2K5;
      eff_tp     = ldc_pkg::TP_25;
      if (strap_code_q[1]) begin
        eff_src      = ldc_pkg::SRC_PASS;
        eff_dim_mode = 1'b0;
      end else if (strap_code_q[0]) begin
        eff_dim_mode = 1'b1;
      end else begin
        eff_dim_mode = 1'b0;
      end
    end
  end

  ldc_duty_meter u_duty (
    .sys_clk    (sys_clk),
    .resetn     (resetn),
    .tick       (tick_q),
    .pwm_in     (pwm_in),
    .duty       (duty),
    .duty_valid (duty_valid)
  );

  assign map_reg  = map_level(code_q, dither_q, eff_log, eff_dither);
  assign map_duty = map_level(duty, 3'h0, eff_log, 1'b0);
  assign prod     = 27'(map_reg) * 27'(duty);

  always_comb begin
    unique case (eff_src)
      ldc_pkg::SRC_DUTY:    level_d = map_duty;
      ldc_pkg::SRC_REG:     level_d = map_reg;
      ldc_pkg::SRC_PRODUCT: level_d = prod[26:12];
      ldc_pkg::SRC_PASS:    level_d = ldc_pkg::FULL_SCALE;
    endcase
  end

  // one register stage keeps the multiplier off the hybrid path
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      level_q <= 15'h0000;
    end else begin
      level_q <= level_d;
    end
  end

  // threshold is full scale over 8, 4, 2 or 1
  assign shift  = 2'h3 - eff_tp;
  assign thr    = ldc_pkg::FULL_SCALE >> shift;
  assign period = ldc_pkg::rate_period(eff_rate);
  assign scaled = 18'(level_q) << shift;
  assign on_prod = 32'(scaled) * 32'(period);
  assign on_raw = on_prod[27:15];

  always_comb begin
    if (!eff_dim_mode) begin
      dc_out = 1'b1;
    end else if (eff_tp == ldc_pkg::TP_100) begin
      dc_out = (level_q == ldc_pkg::FULL_SCALE);
    end else begin
      dc_out = (level_q >= thr);
    end
  end

  always_comb begin
    if (dc_out) begin
      amp_d  = level_q;
      on_cnt = period;
    end else begin
      amp_d  = thr;
      on_cnt = on_raw;
      // both edges kept clear of the shortest controllable pulse
      if (on_raw != 13'h0000 && on_raw < ldc_pkg::MIN_PULSE) begin
        on_cnt = ldc_pkg::MIN_PULSE;
      end else if (period - on_raw < ldc_pkg::MIN_PULSE) begin
        on_cnt = period - ldc_pkg::MIN_PULSE;
      end
    end
  end

  ldc_string_pwm u_pwm (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .tick        (tick_q),
    .rate_sel    (eff_rate),
    .on_cnt      (on_cnt),
    .amp_in      (amp_d),
    .str_en      (str_en_q),
    .str_on      (gen_on),
    .amp         (gen_amp),
    .cycle_start (gen_cycle),
    .active_cnt  (active_cnt)
  );

  // decision seen by the generator at its latch edge, one cycle back
  // avoids a flag that lags the new amplitude by a cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= ~dc_out;
    end
  end

  // pulse flag follows the generator's own cycle boundary
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pulsing_q <= 1'b0;
    end else if (eff_src == ldc_pkg::SRC_PASS) begin
      pulsing_q <= 1'b0;
    end else if (gen_cycle) begin
      pulsing_q <= pend_q;
    end
  end

  // pass-through bypasses mapping and the hybrid path entirely
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sink_on      <= 8'h00;
      sink_level   <= 15'h0000;
      sink_pulsing <= 1'b0;
    end else if (eff_src == ldc_pkg::SRC_PASS) begin
      sink_on      <= str_en_q & {8{pwm_in}};
      sink_level   <= ldc_pkg::FULL_SCALE;
      sink_pulsing <= 1'b0;
    end else begin
      sink_on      <= gen_on;
      sink_level   <= gen_amp;
      sink_pulsing <= gen_cycle ? pend_q : pulsing_q;
    end
  end
endmodule : ldc_top
